// ==== rtl/dashbp_port.sv ====
// Host parallel bus port of the acquisition device
`timescale 1ns/1ps
`default_nettype none
module dashbp_port
	import dashbp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic muxedBus,
	input wire logic addrLatch,
	input wire logic chipSel_n,
	input wire logic rdStrobe_n,
	input wire logic wrStrobe_n,
	input wire logic [ADDR_W:0] addrIn,
	input wire logic [WORD_W-1:0] dataIn,
	input wire logic bus_width_select,
	input wire logic intSource,
	output logic [WORD_W-1:0] dataOut,
	output logic dataOe,
	output logic intReq_n,
	output logic coreClkEn,
	output logic [SEC_W-1:0] ram_section_pointer,
	output logic [SEC_W-1:0] sectionKind
);
	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [6:0] syncA_reg;                  // First stage
	logic [6:0] syncB_reg;                  // Second stage
	logic [ADDR_W:0] addrA_reg;
	logic [ADDR_W:0] addrB_reg;
	logic [WORD_W-1:0] dataA_reg;
	logic [WORD_W-1:0] dataB_reg;
	logic csN, rdN, wrN, ale, bw, muxS, intS;

	// Two flops on every pin
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			syncA_reg <= 7'h7F;
			syncB_reg <= 7'h7F;
			addrA_reg <= '0;
			addrB_reg <= '0;
			dataA_reg <= WORD_ZERO;
			dataB_reg <= WORD_ZERO;
		end else begin
			syncA_reg <= {chipSel_n, rdStrobe_n, wrStrobe_n, ~addrLatch,
				bus_width_select, muxedBus, ~intSource};
			syncB_reg <= syncA_reg;
			addrA_reg <= addrIn;
			addrB_reg <= addrA_reg;
			dataA_reg <= dataIn;
			dataB_reg <= dataA_reg;
		end
	end
	assign {csN, rdN, wrN} = syncB_reg[6:4];
	assign ale = ~syncB_reg[3];
	assign bw = syncB_reg[2];
	assign muxS = syncB_reg[1];
	assign intS = ~syncB_reg[0];

	// ****************************************************************
	// Address capture
	// ****************************************************************
	logic [ADDR_W:0] addrLatched_reg;       // Address held after strobe
	logic [ADDR_W:0] addrUsed;

	// Address follows the bus while the latch strobe is high, then holds;
	// address and strobe share the sync depth, so they stay aligned
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			addrLatched_reg <= '0;
		end else begin
			if (ale) begin
				addrLatched_reg <= addrB_reg;
			end
		end
	end
	// Multiplexed bus uses latched address, else live address
	assign addrUsed = muxS ? addrLatched_reg : addrB_reg;

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic [ADDR_W-1:0] wordAddr;
	logic laneHi;
	logic [1:0] byteEn;

	// Word index and lane; lane ignored in word mode
	assign wordAddr = addrUsed[ADDR_W:1];
	assign laneHi = bw & addrUsed[0];
	assign byteEn = bw ? (laneHi ? 2'b10 : 2'b01) : 2'b11;

	// Place byte onto the selected lane
	function automatic logic [WORD_W-1:0] laneIn(input logic [WORD_W-1:0] d,
		input logic wide, input logic hi);
		if (wide) begin
			laneIn = d;
		end else begin
			laneIn = {d[BYTE_W-1:0], d[BYTE_W-1:0]};
		end
		if (!wide && !hi) begin
			laneIn = {BYTE_W'(0), d[BYTE_W-1:0]};
		end
	endfunction : laneIn

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	dashbp_state_t state_reg;
	logic wrGo, rdGo;
	assign wrGo = ~csN & ~wrN;
	assign rdGo = ~csN & ~rdN;

	// One write per strobe; read held while strobe low
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= DASHBP_IDLE;
		end else begin
			case (state_reg)
				DASHBP_IDLE: begin
					if (wrGo) begin
						state_reg <= DASHBP_WRITE;
					end else if (rdGo) begin
						state_reg <= DASHBP_READ;
					end
				end
				DASHBP_WRITE: begin
					if (!wrGo) begin
						state_reg <= DASHBP_IDLE;
					end
				end
				DASHBP_READ: begin
					if (!rdGo) begin
						state_reg <= DASHBP_IDLE;
					end
				end
				default: begin
					state_reg <= DASHBP_IDLE;
				end
			endcase
		end
	end
	logic wrPulse;
	assign wrPulse = (state_reg == DASHBP_IDLE) & wrGo;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [WORD_W-1:0] regs_reg [0:NUM_WORDS-1]; // Plain register words
	logic [WORD_W-1:0] wIn;
	logic [SEC_W-1:0] secPtr;
	assign wIn = laneIn(dataB_reg, ~bw, laneHi);

	// Byte writes into plain register words
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				regs_reg[i] <= CFG_RESET;
			end
		end else if (wrPulse && wordAddr != ADDR_IRAM
			&& 32'(wordAddr) < NUM_WORDS) begin
			if (byteEn[0]) begin
				regs_reg[wordAddr][BYTE_W-1:0] <= wIn[BYTE_W-1:0];
			end
			if (byteEn[1]) begin
				regs_reg[wordAddr][WORD_W-1:BYTE_W] <= wIn[WORD_W-1:BYTE_W];
			end
		end
	end
	assign secPtr = regs_reg[ADDR_CFG][SEC_LSB+SEC_W-1:SEC_LSB];

	// Slot within a section advances on each full word access
	logic [SLOT_W-1:0] slot_reg;
	logic ramHit, slotStep;
	assign ramHit = (wordAddr == ADDR_IRAM);
	assign slotStep = ramHit & (state_reg != DASHBP_IDLE) & (rdN & wrN)
		& (~bw | laneHi);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			slot_reg <= SLOT_RESET;
		end else if (wrPulse && !ramHit && wordAddr == ADDR_CFG) begin
			slot_reg <= SLOT_RESET;         // Pointer write restarts slots
		end else if (slotStep) begin
			slot_reg <= slot_reg + 3'h1;
		end
	end

	// Instruction RAM, eight words per section
	logic [WORD_W-1:0] ramRd;
	dashbp_ram uRam (
		.clk_sys(clk_sys),
		.wrEn(wrPulse & ramHit),
		.byteEn(byteEn),
		.addr({secPtr, slot_reg}),
		.wrData(wIn),
		.rdData(ramRd)
	);

	// ****************************************************************
	// Read data and outputs
	// ****************************************************************
	logic [WORD_W-1:0] rdWord;
	assign rdWord = ramHit ? ramRd
		: (32'(wordAddr) < NUM_WORDS ? regs_reg[wordAddr] : WORD_ZERO);

	// Drive bus only during a selected read
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dataOut <= WORD_ZERO;
			dataOe <= 1'b0;
		end else begin
			dataOe <= rdGo;
			if (!bw) begin
				dataOut <= rdWord;
			end else if (laneHi) begin
				dataOut <= {BYTE_W'(0), rdWord[WORD_W-1:BYTE_W]};
			end else begin
				dataOut <= {BYTE_W'(0), rdWord[BYTE_W-1:0]};
			end
		end
	end

	// Interrupt, clock pause and section outputs
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			intReq_n <= 1'b1;
			coreClkEn <= 1'b1;
			ram_section_pointer <= SEC_INSTR;
			sectionKind <= SEC_INSTR;
		end else begin
			intReq_n <= ~intS;
			coreClkEn <= csN;
			ram_section_pointer <= secPtr;
			case (secPtr)
				SEC_LIM1: sectionKind <= SEC_LIM1;
				SEC_LIM2: sectionKind <= SEC_LIM2;
				default: sectionKind <= SEC_INSTR;
			endcase
		end
	end
endmodule : dashbp_port
`default_nettype wire

// ==== shared/dashbp_pkg.sv ====
// Package of constants for the host bus port
package dashbp_pkg;
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int ADDR_W = 4;                  // Word address width (16 words)
	localparam int WORD_W = 16;                 // Register word width
	localparam int BYTE_W = 8;                  // Byte lane width
	localparam int NUM_WORDS = 14;              // 28 byte locations in 8-bit mode
	localparam int SEC_W = 2;                   // Section pointer width
	localparam int SLOT_W = 3;                  // Eight words per section
	localparam int MEM_AW = 5;                  // Section x slot
	// ****************************************************************
	// Map
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADDR_IRAM = 4'h0; // Shared instruction RAM
	localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h1;  // Configuration register
	localparam int SEC_LSB = 8;                 // Section pointer field position
	localparam logic [WORD_W-1:0] CFG_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [SEC_W-1:0] SEC_INSTR = 2'h0; // Instruction section
	localparam logic [SEC_W-1:0] SEC_LIM1 = 2'h1;  // First limit set
	localparam logic [SEC_W-1:0] SEC_LIM2 = 2'h2;  // Second limit set
	localparam logic [SLOT_W-1:0] SLOT_RESET = 3'h0;
	typedef enum logic [1:0] {
		DASHBP_IDLE = 2'b00,
		DASHBP_WRITE = 2'b01,
		DASHBP_READ = 2'b10
	} dashbp_state_t;
endpackage : dashbp_pkg

// ==== rtl/dashbp_ram.sv ====
// Instruction RAM with byte writes and registered read data
`timescale 1ns/1ps
`default_nettype none
module dashbp_ram
	import dashbp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic wrEn,
	input wire logic [1:0] byteEn,
	input wire logic [MEM_AW-1:0] addr,
	input wire logic [WORD_W-1:0] wrData,
	output logic [WORD_W-1:0] rdData
);
	// Storage words
	logic [WORD_W-1:0] mem [0:(1<<MEM_AW)-1];

	// ****************************************************************
	// Write per byte lane, read registered
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (wrEn && byteEn[0]) begin
			mem[addr][BYTE_W-1:0] <= wrData[BYTE_W-1:0];
		end
		if (wrEn && byteEn[1]) begin
			mem[addr][WORD_W-1:BYTE_W] <= wrData[WORD_W-1:BYTE_W];
		end
		rdData <= mem[addr];
	end
endmodule : dashbp_ram
`default_nettype wire

// ==== dv/dashbp_checker.sv ====
// Assertion checker for the host bus port
`timescale 1ns/1ps
`default_nettype none
module dashbp_checker
	import dashbp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic chipSel_n,
	input wire logic rdStrobe_n,
	input wire logic wrStrobe_n,
	input wire logic bus_width_select,
	input wire logic intSource,
	input wire logic [WORD_W-1:0] dataOut,
	input wire logic dataOe,
	input wire logic intReq_n,
	input wire logic coreClkEn,
	input wire logic [SEC_W-1:0] ram_section_pointer,
	input wire logic [SEC_W-1:0] sectionKind
);
	// Selected read and write strobes
	wire logic rdSel = !chipSel_n && !rdStrobe_n;
	wire logic wrSel = !chipSel_n && !wrStrobe_n;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// ********
	// Pins pass two sync flops and one register
	// ********
	sequence s_rd3;
		rdSel[*3];
	endsequence
	sequence s_cs3;
		(!chipSel_n)[*3];
	endsequence
	property p_oe_on;
		s_rd3 |=> dataOe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("no drive");
	property p_oe_why;
		dataOe |-> $past(rdSel, 3);
	endproperty
	a_oe_why: assert property (p_oe_why) else $error("stray drive");
	property p_oe_off;
		$rose(rdStrobe_n) |-> ##3 !dataOe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("drive held");
	property p_hi_zero;
		dataOe && bus_width_select && $past(bus_width_select, 3)
			|-> dataOut[WORD_W-1:BYTE_W] == 8'h00;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper byte");
	property p_pause;
		s_cs3 |=> !coreClkEn;
	endproperty
	a_pause: assert property (p_pause) else $error("clock runs");
	property p_run;
		chipSel_n[*3] |=> coreClkEn;
	endproperty
	a_run: assert property (p_run) else $error("clock stuck");
	property p_kind;
		$stable(ram_section_pointer) |-> sectionKind ==
			((ram_section_pointer == 2'h3) ? SEC_INSTR : ram_section_pointer);
	endproperty
	a_kind: assert property (p_kind) else $error("bad kind");
	property p_ptr_wr;
		$changed(ram_section_pointer) |-> $past(wrSel, 3) || $past(wrSel, 4);
	endproperty
	a_ptr_wr: assert property (p_ptr_wr) else $error("ptr moved");
	property p_int_on;
		intSource[*3] |=> !intReq_n;
	endproperty
	a_int_on: assert property (p_int_on) else $error("no request");
	property p_int_off;
		(!intSource)[*3] |=> intReq_n;
	endproperty
	a_int_off: assert property (p_int_off) else $error("stuck req");
endmodule : dashbp_checker
bind dashbp_port dashbp_checker CHK (.clk_sys, .arst_n, .chipSel_n,
	.rdStrobe_n, .wrStrobe_n, .bus_width_select, .intSource, .dataOut,
	.dataOe, .intReq_n, .coreClkEn, .ram_section_pointer, .sectionKind);
`default_nettype wire

// ==== dv/dashbp_host.sv ====
// Host bus master model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module dashbp_host
	import dashbp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic muxedBus,
	input wire logic [WORD_W-1:0] dataOut,
	output logic addrLatch,
	output logic chipSel_n,
	output logic rdStrobe_n,
	output logic wrStrobe_n,
	output logic [ADDR_W:0] addrIn,
	output logic [WORD_W-1:0] dataIn
);
	logic csEn = 1'b0; // Strobe phase
	logic hiAddr = 1'b0; // High host address bit
	// Select decoded from one high address bit
	assign chipSel_n = !(csEn && hiAddr);
	initial begin
		addrLatch = 1'b0;
		rdStrobe_n = 1'b1;
		wrStrobe_n = 1'b1;
		addrIn = 5'h00;
		dataIn = 16'h0000;
	end
	// One access: latch, strobe, hold, release
	task automatic xfer(input logic sel, input logic wr,
		input logic [ADDR_W:0] a, input logic [WORD_W-1:0] d,
		output logic [WORD_W-1:0] q);
		@(posedge clk_sys) #1;
		addrIn = a;
		hiAddr = sel;
		addrLatch = muxedBus;
		@(posedge clk_sys) #1;
		addrLatch = 1'b0;
		// Shared lines move on after the latch
		if (muxedBus) addrIn = ~a;
		dataIn = wr ? d : ~dataIn;
		@(posedge clk_sys) #1;
		csEn = 1'b1;
		wrStrobe_n = !wr;
		rdStrobe_n = wr;
		repeat (6) @(posedge clk_sys);
		q = dataOut;
		#1 csEn = 1'b0;
		wrStrobe_n = 1'b1;
		rdStrobe_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		// Released lines do not keep their value
		#1 hiAddr = 1'b0;
		dataIn = ~dataIn;
		addrIn = ~addrIn;
	endtask : xfer
endmodule : dashbp_host
`default_nettype wire

// ==== dv/das_host_bus_port_tb_top.sv ====
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module das_host_bus_port_tb_top
	import dashbp_pkg::*;
;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic muxedBus = 1'b0;
	logic bus_width_select = 1'b0;
	logic intSource = 1'b0;
	logic addrLatch, chipSel_n, rdStrobe_n, wrStrobe_n;
	logic dataOe, intReq_n, coreClkEn;
	logic [ADDR_W:0] addrIn;
	logic [WORD_W-1:0] dataIn, dataOut, rdq;
	logic [SEC_W-1:0] ptr, kind;
	int n_fail = 0;
	int num_checks = 0;
	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;
	dashbp_port DUT (.clk_sys, .arst_n, .muxedBus, .addrLatch, .chipSel_n,
		.rdStrobe_n, .wrStrobe_n, .addrIn, .dataIn, .bus_width_select,
		.intSource, .dataOut, .dataOe, .intReq_n, .coreClkEn,
		.ram_section_pointer(ptr), .sectionKind(kind));
	dashbp_host HOST (.clk_sys, .muxedBus, .dataOut, .addrLatch, .chipSel_n,
		.rdStrobe_n, .wrStrobe_n, .addrIn, .dataIn);
	// ********
	// Helpers
	// ********
	task automatic chk(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W:0] a, input logic [WORD_W-1:0] d);
		HOST.xfer(1'b1, 1'b1, a, d, rdq);
	endtask : wr
	task automatic rd(input logic [ADDR_W:0] a, input logic [WORD_W-1:0] e);
		fork
			HOST.xfer(1'b1, 1'b0, a, 16'h0000, rdq);
			begin
				repeat (7) @(posedge clk_sys);
				chk(16'({dataOe, coreClkEn}), 16'h0002);
			end
		join
		chk(rdq, e);
		chk(16'({dataOe, coreClkEn}), 16'h0001);
	endtask : rd
	function automatic logic [WORD_W-1:0] pat(input int s, input int w);
		return 16'hA000 + 16'(s * 256 + w);
	endfunction : pat
	// ********
	// Scenarios
	// ********
	task automatic t_sections;
		for (int s = 0; s < 4; s++) begin
			wr(5'h03, 16'(s) << SEC_LSB);
			chk(16'(ptr), 16'(s));
			chk(16'(kind), (s == 3) ? 16'h0000 : 16'(s));
			rd(5'h02, 16'(s) << SEC_LSB);
		end
		$display("sections done");
	endtask : t_sections
	task automatic t_ram;
		for (int s = 0; s < 3; s++) begin
			wr(5'h02, 16'(s) << SEC_LSB);
			for (int w = 0; w < 8; w++) wr(5'h00, pat(s, w));
		end
		for (int s = 2; s >= 0; s--) begin
			wr(5'h02, 16'(s) << SEC_LSB);
			for (int w = 0; w < 8; w++) rd(5'h01, pat(s, w));
		end
		$display("ram done");
	endtask : t_ram
	task automatic t_bytes;
		muxedBus = 1'b1;
		bus_width_select = 1'b1;
		repeat (4) @(posedge clk_sys);
		wr(5'h02, 16'h00A5);
		wr(5'h03, 16'h0002);
		chk(16'(ptr), 16'h0002);
		rd(5'h02, 16'h00A5);
		rd(5'h03, 16'h0002);
		wr(5'h00, 16'h0034);
		wr(5'h01, 16'h0012);
		wr(5'h03, 16'h0002);
		rd(5'h00, 16'h0034);
		rd(5'h01, 16'h0012);
		rd(5'h00, 16'h0001);
		rd(5'h01, 16'h00A2);
		wr(5'h1C, 16'h00FF);
		rd(5'h1C, 16'h0000);
		muxedBus = 1'b0;
		bus_width_select = 1'b0;
		repeat (4) @(posedge clk_sys);
		$display("bytes done");
	endtask : t_bytes
	task automatic t_refuse;
		HOST.xfer(1'b0, 1'b1, 5'h02, 16'h0100, rdq);
		chk(16'(ptr), 16'h0002);
		wr(5'h1E, 16'hFFFF);
		rd(5'h1E, 16'h0000);
		rd(5'h03, 16'h02A5);
		$display("refuse done");
	endtask : t_refuse
	task automatic t_int;
		intSource = 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(16'(intReq_n), 16'h0000);
		#1 intSource = 1'b0;
		repeat (5) @(posedge clk_sys);
		chk(16'(intReq_n), 16'h0001);
		$display("int done");
	endtask : t_int
	task automatic close_out;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	// Main sequence after a two cycle reset
	initial begin
		repeat (2) @(posedge clk_sys);
		#1 arst_n = 1'b1;
		chk({dataOe, intReq_n, coreClkEn, ptr, kind, 9'h000}, 16'h6000);
		chk(dataOut, 16'h0000);
		t_sections();
		t_ram();
		t_bytes();
		t_refuse();
		t_int();
		close_out();
	end
	// Watchdog: about ten times the expected run
	initial begin
		#100000;
		n_fail++;
		close_out();
	end
endmodule : das_host_bus_port_tb_top
`default_nettype wire
